// [hdl/sfr_bank1_pkg.sv]
package sfr_bank1_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte address = offset, on the 8-bit word bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_INDIRECT_DATA_PORT = 8'h80;
  localparam logic [7:0] ADDR_TIMER_PRESCALE_CONFIG = 8'h81;
  localparam logic [7:0] ADDR_PC_LOW_BYTE = 8'h82;
  localparam logic [7:0] ADDR_ALU_STATUS = 8'h83;
  localparam logic [7:0] ADDR_INDIRECT_POINTER = 8'h84;
  localparam logic [7:0] ADDR_PORT_A_DIRECTION = 8'h85;
  localparam logic [7:0] ADDR_PORT_B_DIRECTION = 8'h86;
  localparam logic [7:0] ADDR_PORT_C_DIRECTION = 8'h87;
  localparam logic [7:0] ADDR_PC_HIGH_LATCH = 8'h8a;
  localparam logic [7:0] ADDR_INTERRUPT_CONTROL = 8'h8b;
  localparam logic [7:0] ADDR_PERIPHERAL_IRQ_ENABLE = 8'h8c;
  localparam logic [7:0] ADDR_RESET_CAUSE = 8'h8e;
  localparam logic [7:0] ADDR_TIMER2_PERIOD = 8'h92;
  localparam logic [7:0] ADDR_SERIAL_SLAVE_ADDRESS = 8'h93;
  localparam logic [7:0] ADDR_SERIAL_PORT_STATUS = 8'h94;
  localparam logic [7:0] ADDR_ANALOG_PIN_CONFIG = 8'h9f;
  // Bank-0 mirror of the shared core registers
  localparam logic [7:0] BANK_BIT_MASK = 8'h7f;

  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int ST_CARRY = 0;
  localparam int ST_HALF_CARRY = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_POWERDOWN = 3;
  localparam int ST_WATCHDOG = 4;
  localparam logic [7:0] ST_FLAG_MASK = 8'h07;
  localparam logic [7:0] ST_SW_MASK = 8'he7;
  localparam logic [7:0] ST_CLEAR_VALUE = 8'h04;

  // ----------------------------------------------------------------
  // Implemented-bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_PORT_A = 8'h3f;
  localparam logic [7:0] MASK_PC_HIGH = 8'h1f;
  localparam logic [7:0] MASK_PIE = 8'h4f;
  localparam logic [7:0] MASK_RESET_CAUSE = 8'h03;
  localparam logic [7:0] MASK_ANALOG = 8'h07;

  // ----------------------------------------------------------------
  // Reset values (power-up / brown-out and other resets)
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ALL_ONES = 8'hff;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PORT_A = 8'h3f;
  localparam logic [7:0] RST_STATUS_POR = 8'h18;
  localparam logic [7:0] RST_STATUS_OTHER_CLR = 8'h1f;
  localparam logic [7:0] RST_INTERRUPT_CONTROL_OTHER_KEEP = 8'h01;

  // ----------------------------------------------------------------
  // Data memory and ALU operations
  // ----------------------------------------------------------------
  localparam int RAM_WORDS = 256;

  typedef enum logic [2:0] {
    ALU_NONE,
    ALU_ADD,
    ALU_SUB,
    ALU_LOGIC,
    ALU_CLEAR
  } alu_op_type;

endpackage

// [hdl/sfr_bank1.sv]
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// What this block does
// [R1] Status is written like any other register by any instruction.
// [R2] A flag-affecting write to status keeps written data off Z, DC, C.
// [R3] Z comes from the instruction result on flag-affecting ops; DC and C only on add and subtract.
// [R4] Writes never change the watchdog-expiry and power-down flags.
// [R5] Clear-file on status clears bits 7:5, sets Z, keeps the rest.
// [R6] Software should alter status only with bit, swap or move ops.
// [R7] On subtract, carry and half carry read one when no borrow occurs.
// [R8] Software keeps status bits 7 and 6 clear; the block stores them as written.
// [R9] Core registers answer at the same location in both banks.
// [R10] The pc high latch holds five bits that load pc bits 12 to 8.
// [R11] Unused addresses and bit positions read as zero.
// [R12] Power-up/brown-out and other resets load different reset sets.
// [R13] Without converter, software keeps its enable and pin config zero.
// [R14] Every reset makes port A pins inputs via all-ones direction.
// [R15] The timer prescale config register is fully read/write.
// [R16] The indirect port reaches memory at the pointer; self reads zero.
module sfr_bank1
  import sfr_bank1_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic power_reset,
  input wire logic watchdog_reset,
  input wire logic sleep_entry,
  input wire logic wdt_clear,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [7:0] avs_writedata,
  input wire sfr_bank1_pkg::alu_op_type alu_op,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  input wire logic pc_load,
  output logic [7:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [7:0] port_a_dir,
  output logic [7:0] timer_cfg,
  output logic [12:0] pc_q,
  output logic [7:0] status_out
);
  import sfr_bank1_pkg::*;

  // ----------------------------------------------------------------
  // Bus handshake: one wait cycle, answer at the second edge
  // ----------------------------------------------------------------
  logic ack_q;
  logic [7:0] reg_addr;
  logic wr_en;
  logic rd_en;
  logic [7:0] ram_q [RAM_WORDS];
  logic [7:0] target;
  logic [7:0] alu_res;
  logic [7:0] status_q;
  logic [7:0] option_q, fsr_q, tris_a_q, tris_b_q, tris_c_q, pc_high_latch_q;
  logic [7:0] interrupt_control_q, pie_q, reset_cause_q, pr2_q, serial_slave_address_q, serial_port_status_q, adcon_q;
  logic flag_op;
  logic c_d, dc_d, z_d;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] rd_d;

  assign wr_en = avs_write && !ack_q;
  assign rd_en = avs_read && !ack_q;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
    end
  end

  // ----------------------------------------------------------------
  // Address mirroring and indirect target
  // ----------------------------------------------------------------
  always_comb begin
    reg_addr = avs_address;
    case (avs_address & BANK_BIT_MASK)
      (ADDR_INDIRECT_DATA_PORT & BANK_BIT_MASK),
      (ADDR_PC_LOW_BYTE & BANK_BIT_MASK),
      (ADDR_ALU_STATUS & BANK_BIT_MASK),
      (ADDR_INDIRECT_POINTER & BANK_BIT_MASK),
      (ADDR_PC_HIGH_LATCH & BANK_BIT_MASK),
      (ADDR_INTERRUPT_CONTROL & BANK_BIT_MASK): begin
        reg_addr = avs_address | ~BANK_BIT_MASK; // R9
      end
      default: begin
        reg_addr = avs_address;
      end
    endcase
  end

  assign target = (reg_addr == ADDR_INDIRECT_DATA_PORT) ? fsr_q : reg_addr;

  // ----------------------------------------------------------------
  // Result and flag logic
  // ----------------------------------------------------------------
  always_comb begin
    sum9 = 9'h000;
    sum5 = 5'h00;
    flag_op = 1'b1;
    alu_res = avs_writedata;
    case (alu_op)
      ALU_ADD: begin
        sum9 = {1'b0, alu_a} + {1'b0, alu_b};
        sum5 = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
        alu_res = sum9[7:0];
      end
      ALU_SUB: begin
        // Two's complement add makes carry an inverted borrow
        sum9 = {1'b0, alu_a} + {1'b0, ~alu_b} + 9'h001; // R7
        sum5 = {1'b0, alu_a[3:0]} + {1'b0, ~alu_b[3:0]} + 5'h01; // R7
        alu_res = sum9[7:0];
      end
      ALU_LOGIC: begin
        alu_res = avs_writedata;
      end
      ALU_CLEAR: begin
        alu_res = 8'h00;
      end
      default: begin
        flag_op = 1'b0;
      end
    endcase
    z_d = (alu_res == 8'h00); // R3
    c_d = (alu_op == ALU_ADD || alu_op == ALU_SUB) ? sum9[8]
        : status_q[ST_CARRY]; // R3
    dc_d = (alu_op == ALU_ADD || alu_op == ALU_SUB) ? sum5[4]
        : status_q[ST_HALF_CARRY]; // R3
  end

  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= RST_STATUS_POR;
    end else if (power_reset) begin
      status_q <= RST_STATUS_POR; // R12
    end else if (watchdog_reset) begin
      // Other resets clear 7:5, keep flags, drop watchdog-expiry flag
      status_q <= (status_q & RST_STATUS_OTHER_CLR)
          & ~(8'h01 << ST_WATCHDOG); // R12
    end else begin
      if (wr_en && target == ADDR_ALU_STATUS) begin
        if (alu_op == ALU_CLEAR) begin
          status_q <= (status_q & 8'h1b) | ST_CLEAR_VALUE; // R5
        end else if (flag_op) begin
          status_q <= (alu_res & ST_SW_MASK & ~ST_FLAG_MASK)
              | (status_q & ~ST_SW_MASK)
              | {5'h00, z_d, dc_d, c_d}; // R2
        end else begin
          status_q <= (avs_writedata & ST_SW_MASK)
              | (status_q & ~ST_SW_MASK); // R1 R4
        end
      end else if (flag_op && wr_en) begin
        status_q[ST_ZERO] <= z_d; // R3
        status_q[ST_HALF_CARRY] <= dc_d;
        status_q[ST_CARRY] <= c_d;
      end
      if (sleep_entry) begin
        status_q[ST_POWERDOWN] <= 1'b0;
        status_q[ST_WATCHDOG] <= 1'b1;
      end else if (wdt_clear) begin
        status_q[ST_POWERDOWN] <= 1'b1;
        status_q[ST_WATCHDOG] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Plain control registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      option_q <= RST_ALL_ONES;
      tris_a_q <= RST_PORT_A;
      tris_b_q <= RST_ALL_ONES;
      tris_c_q <= RST_ALL_ONES;
      pc_high_latch_q <= RST_ZERO;
      interrupt_control_q <= RST_ZERO;
      pie_q <= RST_ZERO;
      pr2_q <= RST_ALL_ONES;
      serial_slave_address_q <= RST_ZERO;
      serial_port_status_q <= RST_ZERO;
      adcon_q <= RST_ZERO;
      fsr_q <= RST_ZERO;
    end else if (power_reset || watchdog_reset) begin
      option_q <= RST_ALL_ONES;
      tris_a_q <= RST_PORT_A; // R14
      tris_b_q <= RST_ALL_ONES;
      tris_c_q <= RST_ALL_ONES;
      pc_high_latch_q <= RST_ZERO;
      pie_q <= RST_ZERO;
      pr2_q <= RST_ALL_ONES;
      serial_slave_address_q <= RST_ZERO;
      serial_port_status_q <= RST_ZERO;
      adcon_q <= RST_ZERO;
      interrupt_control_q <= power_reset ? RST_ZERO
          : (interrupt_control_q & RST_INTERRUPT_CONTROL_OTHER_KEEP); // R12
    end else if (wr_en) begin
      case (target)
        ADDR_TIMER_PRESCALE_CONFIG: option_q <= avs_writedata; // R15
        ADDR_INDIRECT_POINTER: fsr_q <= avs_writedata;
        ADDR_PORT_A_DIRECTION: tris_a_q <= avs_writedata & MASK_PORT_A;
        ADDR_PORT_B_DIRECTION: tris_b_q <= avs_writedata;
        ADDR_PORT_C_DIRECTION: tris_c_q <= avs_writedata;
        ADDR_PC_HIGH_LATCH: pc_high_latch_q <= avs_writedata & MASK_PC_HIGH;
        ADDR_INTERRUPT_CONTROL: interrupt_control_q <= avs_writedata;
        ADDR_PERIPHERAL_IRQ_ENABLE: pie_q <= avs_writedata & MASK_PIE;
        ADDR_TIMER2_PERIOD: pr2_q <= avs_writedata;
        ADDR_SERIAL_SLAVE_ADDRESS: serial_slave_address_q <= avs_writedata;
        ADDR_SERIAL_PORT_STATUS: serial_port_status_q <= avs_writedata & 8'hc0;
        ADDR_ANALOG_PIN_CONFIG: adcon_q <= avs_writedata & MASK_ANALOG;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_cause_q <= RST_ZERO;
    end else if (power_reset) begin
      reset_cause_q <= RST_ZERO;
    end else if (wr_en && target == ADDR_RESET_CAUSE) begin
      reset_cause_q <= avs_writedata & MASK_RESET_CAUSE;
    end
  end

  // ----------------------------------------------------------------
  // Program counter and data memory
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_q <= 13'h0000;
    end else if (power_reset || watchdog_reset) begin
      pc_q <= 13'h0000;
    end else if (wr_en && target == ADDR_PC_LOW_BYTE) begin
      pc_q <= {pc_high_latch_q[4:0], avs_writedata}; // R10
    end else if (pc_load) begin
      pc_q <= {pc_high_latch_q[4:0], pc_q[7:0]}; // R10
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr_en && target[7] == 1'b0) begin
      ram_q[target] <= avs_writedata; // R16
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    case (target)
      ADDR_INDIRECT_DATA_PORT: rd_d = 8'h00; // R16
      ADDR_TIMER_PRESCALE_CONFIG: rd_d = option_q;
      ADDR_PC_LOW_BYTE: rd_d = pc_q[7:0];
      ADDR_ALU_STATUS: rd_d = status_q;
      ADDR_INDIRECT_POINTER: rd_d = fsr_q;
      ADDR_PORT_A_DIRECTION: rd_d = tris_a_q;
      ADDR_PORT_B_DIRECTION: rd_d = tris_b_q;
      ADDR_PORT_C_DIRECTION: rd_d = tris_c_q;
      ADDR_PC_HIGH_LATCH: rd_d = pc_high_latch_q;
      ADDR_INTERRUPT_CONTROL: rd_d = interrupt_control_q;
      ADDR_PERIPHERAL_IRQ_ENABLE: rd_d = pie_q;
      ADDR_RESET_CAUSE: rd_d = reset_cause_q;
      ADDR_TIMER2_PERIOD: rd_d = pr2_q;
      ADDR_SERIAL_SLAVE_ADDRESS: rd_d = serial_slave_address_q;
      ADDR_SERIAL_PORT_STATUS: rd_d = serial_port_status_q;
      ADDR_ANALOG_PIN_CONFIG: rd_d = adcon_q;
      default: rd_d = target[7] ? 8'h00 : ram_q[target]; // R11
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 8'h00;
    end else if (rd_en) begin
      avs_readdata <= rd_d;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_a_dir <= RST_PORT_A;
      timer_cfg <= RST_ALL_ONES;
      status_out <= RST_STATUS_POR;
    end else begin
      port_a_dir <= tris_a_q;
      timer_cfg <= option_q;
      status_out <= status_q;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_wd_flags_kept;
    @(posedge core_clk) disable iff (!reset_n)
    (wr_en && target == ADDR_ALU_STATUS && !sleep_entry && !wdt_clear
        && !power_reset && !watchdog_reset)
    |=> status_q[4:3] == $past(status_q[4:3]);
  endproperty
  a_wd_flags_kept: assert property (p_wd_flags_kept) // R4
    else $error("status reset-cause flags changed by a write");

  property p_clear_sets_zero;
    @(posedge core_clk) disable iff (!reset_n)
    (wr_en && target == ADDR_ALU_STATUS && alu_op == ALU_CLEAR
        && !power_reset && !watchdog_reset)
    |=> status_q[7:5] == 3'b000 && status_q[ST_ZERO];
  endproperty
  a_clear_sets_zero: assert property (p_clear_sets_zero) // R5
    else $error("clear of status did not give expected bits");

  property p_porta_inputs;
    @(posedge core_clk) disable iff (!reset_n)
    (power_reset || watchdog_reset) |=> tris_a_q == MASK_PORT_A ##1
      port_a_dir == MASK_PORT_A;
  endproperty
  a_porta_inputs: assert property (p_porta_inputs) // R14
    else $error("port A not inputs after reset");

  property p_unmapped_zero;
    @(posedge core_clk) disable iff (!reset_n)
    (rd_en && (avs_address == 8'h88 || avs_address == 8'h95))
    |=> avs_readdata == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) // R11
    else $error("unmapped address read nonzero");

  property p_pc_high_latch_bits;
    @(posedge core_clk) disable iff (!reset_n)
    pc_high_latch_q[7:5] == 3'b000;
  endproperty
  a_pc_high_latch_bits: assert property (p_pc_high_latch_bits) // R10
    else $error("pc high latch has bits above four");

  property p_answer_time;
    @(posedge core_clk) disable iff (!reset_n)
    $rose(avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_answer_time: assert property (p_answer_time) // bus handshake
    else $error("bus answer not after one wait cycle");

  property p_por_status;
    @(posedge core_clk) disable iff (!reset_n)
    power_reset |=> status_q[7:3] == 5'b00011;
  endproperty
  a_por_status: assert property (p_por_status) // R12
    else $error("power-up status value wrong");

  property p_sub_carry;
    @(posedge core_clk) disable iff (!reset_n)
    (wr_en && alu_op == ALU_SUB
        && alu_a >= alu_b && !power_reset && !watchdog_reset)
    |=> status_q[ST_CARRY];
  endproperty
  a_sub_carry: assert property (p_sub_carry) // R7
    else $error("subtract without borrow did not set carry");

endmodule

// [verif/sfr_bank1_test.sv]
`timescale 1ns/1ps
module sfr_bank1_test;
  import sfr_bank1_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus, design and tables
  // ----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  // Pulse inputs: sleep, wdt clear, pc load, watchdog reset, power reset
  logic [4:0] pulse_q = 5'h00;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [7:0] avs_writedata = 8'h00;
  alu_op_type alu_op = ALU_NONE;
  logic [7:0] alu_a = 8'h00;
  logic [7:0] alu_b = 8'h00;
  logic [7:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] port_a_dir;
  logic [7:0] timer_cfg;
  logic [12:0] pc_q;
  logic [7:0] status_out;
  int n_errors = 0;
  int tests_run = 0;
  logic [7:0] rv_addr [17] = '{8'h81, 8'h82, 8'h83, 8'h85, 8'h86, 8'h87,
    8'h8a, 8'h8c, 8'h92, 8'h9f, 8'h88, 8'h89, 8'h8d, 8'h8f, 8'h91, 8'h95,
    8'h9e};
  logic [7:0] rv_exp [17] = '{8'hff, 8'h00, 8'h18, 8'h3f, 8'hff, 8'hff,
    8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00};
  logic [7:0] rw_addr [11] = '{8'h81, 8'h85, 8'h86, 8'h87, 8'h8a, 8'h8c,
    8'h8e, 8'h92, 8'h9f, 8'h88, 8'h96};
  // Converter enable and analog pin config stay zero
  logic [7:0] rw_data [11] = '{8'ha5, 8'hff, 8'h5a, 8'hc3, 8'hff, 8'hbf,
    8'hff, 8'h3c, 8'hf8, 8'hff, 8'hff};
  logic [7:0] rw_exp [11] = '{8'ha5, 8'h3f, 8'h5a, 8'hc3, 8'h1f, 8'h0f,
    8'h03, 8'h3c, 8'h00, 8'h00, 8'h00};
  alu_op_type al_op [4] = '{ALU_ADD, ALU_ADD, ALU_SUB, ALU_ADD};
  logic [7:0] al_a [4] = '{8'h0f, 8'hf0, 8'h05, 8'h01};
  logic [7:0] al_b [4] = '{8'h01, 8'h10, 8'h05, 8'h01};
  logic [7:0] al_data [4] = '{8'h05, 8'h02, 8'h00, 8'h07};
  logic [7:0] al_exp [4] = '{8'h1a, 8'h1d, 8'h1f, 8'h18};

  always #50 core_clk = ~core_clk;

  sfr_bank1 dut_u (
    .core_clk(core_clk), .reset_n(reset_n),
    .power_reset(pulse_q[4]), .watchdog_reset(pulse_q[3]),
    .sleep_entry(pulse_q[0]), .wdt_clear(pulse_q[1]),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b), .pc_load(pulse_q[2]),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .port_a_dir(port_a_dir), .timer_cfg(timer_cfg), .pc_q(pc_q),
    .status_out(status_out)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask

  // One Avalon transfer; request held until waitrequest is seen low
  task automatic xfer(input logic wr, input logic [7:0] addr,
      input logic [7:0] data, input alu_op_type op,
      output logic [7:0] rdata);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= addr;
    avs_writedata <= data;
    alu_op <= op;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      n_errors++;
      $display("ERROR at %0t: no answer at address %h", $time, addr);
    end
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    alu_op <= ALU_NONE;
  endtask

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] r;
    xfer(1'b1, addr, data, ALU_NONE, r);
  endtask

  task automatic read_check(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] r;
    xfer(1'b0, addr, 8'h00, ALU_NONE, r);
    check(r, exp);
  endtask

  task automatic pulse(input int i);
    @(posedge core_clk);
    pulse_q[i] <= 1'b1;
    @(posedge core_clk);
    pulse_q[i] <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_values();
    for (int i = 0; i < 17; i++) begin
      read_check(rv_addr[i], rv_exp[i]);
    end
    check(port_a_dir, 8'h3f);
    check(timer_cfg, 8'hff);
  endtask

  task automatic test_rw_masks();
    for (int i = 0; i < 11; i++) begin
      reg_write(rw_addr[i], rw_data[i]);
      read_check(rw_addr[i], rw_exp[i]);
    end
    check(timer_cfg, 8'ha5);
  endtask

  task automatic test_pc_latch();
    reg_write(8'h8a, 8'h15);
    pulse(2);
    check({3'h0, pc_q[12:8]}, 8'h15);
  endtask

  task automatic test_mirror_indirect();
    reg_write(8'h0a, 8'h0c);
    read_check(8'h8a, 8'h0c);
    reg_write(8'h8b, 8'h42);
    read_check(8'h0b, 8'h42);
    reg_write(8'h04, 8'h30);
    read_check(8'h84, 8'h30);
    reg_write(8'h80, 8'h5a);
    read_check(8'h30, 8'h5a);
    read_check(8'h00, 8'h5a);
    reg_write(8'h84, 8'h80);
    read_check(8'h80, 8'h00);
  endtask

  task automatic test_status();
    logic [7:0] r;
    reg_write(8'h83, 8'h27);
    read_check(8'h83, 8'h3f);
    reg_write(8'h83, 8'h00);
    read_check(8'h83, 8'h18);
    for (int i = 0; i < 4; i++) begin
      alu_a <= al_a[i];
      alu_b <= al_b[i];
      xfer(1'b1, 8'h83, al_data[i], al_op[i], r);
      read_check(8'h83, al_exp[i]);
    end
    reg_write(8'h83, 8'h21);
    read_check(8'h83, 8'h39);
    xfer(1'b1, 8'h03, 8'h00, ALU_CLEAR, r);
    read_check(8'h83, 8'h1d);
    xfer(1'b1, 8'h83, 8'h26, ALU_LOGIC, r);
    read_check(8'h83, 8'h39);
    reg_write(8'h83, 8'h05);
    read_check(8'h83, 8'h1d);
  endtask

  task automatic test_sleep_flags();
    pulse(0);
    check(status_out, 8'h15);
    reg_write(8'h83, 8'h1d);
    read_check(8'h83, 8'h15);
    pulse(1);
    check(status_out, 8'h1d);
  endtask

  task automatic test_resets();
    reg_write(8'h85, 8'h00);
    reg_write(8'h81, 8'h00);
    reg_write(8'h8b, 8'hff);
    pulse(3);
    check(port_a_dir, 8'h3f);
    read_check(8'h81, 8'hff);
    read_check(8'h8b, 8'h01);
    read_check(8'h83, 8'h0d);
    read_check(8'h8e, 8'h03);
    reg_write(8'h85, 8'h00);
    pulse(4);
    read_check(8'h85, 8'h3f);
    read_check(8'h83, 8'h18);
    read_check(8'h8e, 8'h00);
    read_check(8'h8a, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    test_reset_values();
    test_rw_masks();
    test_pc_latch();
    test_mirror_indirect();
    test_status();
    test_sleep_flags();
    test_resets();
    stop_test();
  end

  initial begin
    repeat (3000) @(posedge core_clk);
    n_errors++;
    $display("ERROR at %0t: run did not finish in time", $time);
    stop_test();
  end
endmodule
